// ### verilog/mst_pkg.sv
// shared constants for the slot down timer: register addresses, field
// positions, reset values and prescaler step sizes.
// assumes nothing beyond a single clock domain.
package mst_pkg;

    // =========================================================
    // register addresses
    localparam logic [7:0] MST_ADDR_COUNT    = 8'h9C;
    localparam logic [7:0] MST_ADDR_PRESCALE = 8'h9D;
    localparam logic [7:0] MST_ADDR_CONTROL  = 8'h9E;

    // =========================================================
    // control field positions
    localparam int unsigned MST_BIT_EXPIRED  = 6;
    localparam int unsigned MST_BIT_INT_EN   = 4;
    localparam int unsigned MST_BIT_FREE_RUN = 2;
    localparam int unsigned MST_BIT_STEP_HI  = 1;
    localparam int unsigned MST_BIT_STEP_LO  = 0;

    // =========================================================
    // reset values
    localparam logic [7:0] MST_COUNT_RST    = 8'h00;
    localparam logic [7:0] MST_PRESCALE_RST = 8'h00;
    localparam logic [1:0] MST_STEP_RST     = 2'h0;
    localparam logic [7:0] MST_WRAP_VALUE   = 8'hFF;

    // =========================================================
    // prescaler geometry
    localparam int unsigned MST_PRESC_W   = 18;
    localparam int unsigned MST_TERM_W    = 19;
    localparam int unsigned MST_TICK_DIVW = 7;
    localparam logic [8:0]  MST_PR_ZERO_AS = 9'h100;
    // terminal is max << 10, so step = 1024 / factor
    localparam logic [4:0]  MST_STEP_64   = 5'h10;
    localparam logic [4:0]  MST_STEP_128  = 5'h08;
    localparam logic [4:0]  MST_STEP_256  = 5'h04;
    localparam logic [4:0]  MST_STEP_1024 = 5'h01;

    typedef enum logic [1:0] {
        MST_SEL_64,
        MST_SEL_128,
        MST_SEL_256,
        MST_SEL_1024
    } mst_step_t;

endpackage

// ### verilog/mst_tick_div.sv
// system timer tick divider: one-cycle enable at clock / 2^rate_sel.
// assumes rate_sel is steady or that one odd tick on change is harmless.
`timescale 1ns/1ns
module mst_tick_div
    import mst_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [2:0] rate_sel,
    output logic            tick_en
);

    // =========================================================
    // divider
    logic [MST_TICK_DIVW-1:0] cnt_reg;
    logic [MST_TICK_DIVW-1:0] mask;

    assign mask = MST_TICK_DIVW'((8'h01 << rate_sel) - 8'h01);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            tick_en <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
            tick_en <= ((cnt_reg & mask) == mask);
        end
    end

endmodule // mst_tick_div

// ### verilog/mst_prescaler.sv
// 18-bit prescaler stepping toward max << 10; pulses edge_pulse on wrap.
// assumes tick_en is a one-cycle enable from the tick divider.
`timescale 1ns/1ns
module mst_prescaler
    import mst_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       tick_en,
    input  wire logic       run,
    input  wire logic [1:0] step_sel,
    input  wire logic [7:0] prescale_max,
    output logic            edge_pulse
);

    // =========================================================
    // step and terminal
    logic [MST_PRESC_W-1:0] cnt_reg;
    logic [MST_TERM_W-1:0]  term;
    logic [MST_TERM_W-1:0]  sum;
    logic [4:0]             step;

    always_comb begin
        unique case (mst_step_t'(step_sel))
            MST_SEL_64:   step = MST_STEP_64;
            MST_SEL_128:  step = MST_STEP_128;
            MST_SEL_256:  step = MST_STEP_256;
            MST_SEL_1024: step = MST_STEP_1024;
        endcase
    end

    // zero max stands for 256, hence the extra terminal bit
    assign term = {((prescale_max == 8'h00) ? MST_PR_ZERO_AS : {1'b0, prescale_max}),
                   10'h000};
    assign sum  = {1'b0, cnt_reg} + {14'h0000, step};

    // =========================================================
    // counter
    always_ff @(posedge clk) begin
        if (!rst_n || !run) begin
            cnt_reg    <= '0;
            edge_pulse <= 1'b0;
        end else if (tick_en) begin
            if (sum >= term) begin
                cnt_reg    <= '0;
                edge_pulse <= 1'b1;
            end else begin
                cnt_reg    <= sum[MST_PRESC_W-1:0];
                edge_pulse <= 1'b0;
            end
        end else begin
            edge_pulse <= 1'b0;
        end
    end

    // =========================================================
    // checks
    property p_edge_on_tick;
        @(posedge clk) disable iff (!rst_n)
        edge_pulse |-> $past(tick_en);
    endproperty
    a_edge_on_tick: assert property (p_edge_on_tick)
        else $error("prescaler edge without a tick");

    property p_idle_null;
        @(posedge clk) disable iff (!rst_n)
        !run |=> (cnt_reg == '0) && !edge_pulse;
    endproperty
    a_idle_null: assert property (p_idle_null)
        else $error("prescaler not at null while stopped");

endmodule // mst_prescaler

// ### verilog/mst_slot_timer.sv
// mac slot down timer: 8-bit down counter, prescaler, control byte.
// assumes single-cycle sfr strobes and an external irq flag register.
//
// How it works
// - count is readable and drops by one on every active timer edge.
// - reaching zero sets the count expired flag.
// - free-run clear: count sticks at zero, no wrap.
// - free-run set: count wraps from zero to all ones.
// - with interrupt enable, pending flag sets together with expired flag.
// - irq request only with local and global enable both one.
// - a count write loads the value at once.
// - a count write on an active edge stores value minus one.
// - all timer events align to the selected tick rate.
// - 18-bit prescaler, top 8 terminal bits from prescale max.
// - step select sets how fast the prescaler climbs before restart.
// - interval is max times 64, 128, 256 or 1024 ticks.
// - prescale max of zero counts as 256.
// - dma trigger pulses whenever expired flag gets set.
// - registers return to reset after waking from deepest sleep.
// - writing one to expired flag in bit 6 leaves it unchanged.
// - free-run clear: prescaler runs only for nonzero count, from null.
// - free-run set: prescaler runs always, starting from null.
`timescale 1ns/1ns
module mst_slot_timer
    import mst_pkg::*;
(
    input  wire logic       REF_CLK,
    input  wire logic       RSTN,
    input  wire logic [7:0] SFR_ADDR,
    input  wire logic       SFR_WE,
    input  wire logic       SFR_RE,
    input  wire logic [7:0] SFR_WDATA,
    output logic      [7:0] SFR_RDATA,
    input  wire logic [2:0] TICK_RATE_SELECT,
    input  wire logic       SLOT_IRQ_GLOBAL_ENABLE,
    input  wire logic       SLOT_IRQ_PENDING_CLR,
    input  wire logic       SLEEP_WAKE_RESET,
    output logic            SLOT_IRQ_PENDING,
    output logic            SLOT_IRQ,
    output logic            EXPIRY_DMA_TRIGGER
);

    // =========================================================
    // decrement, shared by the write path and the edge path
    function automatic logic [8:0] mst_decrement(input logic [7:0] v, input logic fr);
        logic [8:0] r;
        r = 9'h000;
        if (v == 8'h00) begin
            r = {1'b0, (fr ? MST_WRAP_VALUE : 8'h00)};
        end else begin
            r = {(v == 8'h01), 8'(v - 8'h01)};
        end
        return r;
    endfunction

    // =========================================================
    // state
    logic       blk_rst_n;
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic [7:0] prescale_max_reg;
    logic [1:0] step_sel_reg;
    logic       free_run_reg;
    logic       int_en_reg;
    logic       expired_reg;
    logic       tick_en;
    logic       edge_pulse;
    logic       run;
    logic       wr_count;
    logic       wr_prescale;
    logic       wr_control;
    logic       expire_event;
    logic [8:0] dec_edge;
    logic [8:0] dec_write;

    // wake from deep sleep behaves as a full block reset
    assign blk_rst_n   = RSTN & ~SLEEP_WAKE_RESET;
    assign wr_count    = SFR_WE && (SFR_ADDR == MST_ADDR_COUNT);
    assign wr_prescale = SFR_WE && (SFR_ADDR == MST_ADDR_PRESCALE);
    assign wr_control  = SFR_WE && (SFR_ADDR == MST_ADDR_CONTROL);
    assign run         = free_run_reg || (count_reg != 8'h00);

    // =========================================================
    // tick and prescaler
    mst_tick_div u_tick_div (
        .clk      (REF_CLK),
        .rst_n    (blk_rst_n),
        .rate_sel (TICK_RATE_SELECT),
        .tick_en  (tick_en)
    );

    mst_prescaler u_prescaler (
        .clk          (REF_CLK),
        .rst_n        (blk_rst_n),
        .tick_en      (tick_en),
        .run          (run),
        .step_sel     (step_sel_reg),
        .prescale_max (prescale_max_reg),
        .edge_pulse   (edge_pulse)
    );

    // =========================================================
    // slot count
    assign dec_edge  = mst_decrement(count_reg, free_run_reg);
    assign dec_write = mst_decrement(SFR_WDATA, free_run_reg);

    always_comb begin
        count_next   = count_reg;
        expire_event = 1'b0;
        if (wr_count) begin
            if (edge_pulse) begin
                count_next   = dec_write[7:0];
                expire_event = dec_write[8];
            end else begin
                count_next = SFR_WDATA;
            end
        end else if (edge_pulse) begin
            count_next   = dec_edge[7:0];
            expire_event = dec_edge[8];
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!blk_rst_n) begin
            count_reg <= MST_COUNT_RST;
        end else begin
            count_reg <= count_next;
        end
    end

    // =========================================================
    // prescale max and control fields
    always_ff @(posedge REF_CLK) begin
        if (!blk_rst_n) begin
            prescale_max_reg <= MST_PRESCALE_RST;
        end else if (wr_prescale) begin
            prescale_max_reg <= SFR_WDATA;
        end
    end

    // reserved bits are not stored; they read back zero
    always_ff @(posedge REF_CLK) begin
        if (!blk_rst_n) begin
            int_en_reg   <= 1'b0;
            free_run_reg <= 1'b0;
            step_sel_reg <= MST_STEP_RST;
        end else if (wr_control) begin
            int_en_reg   <= SFR_WDATA[MST_BIT_INT_EN];
            free_run_reg <= SFR_WDATA[MST_BIT_FREE_RUN];
            step_sel_reg <= SFR_WDATA[MST_BIT_STEP_HI:MST_BIT_STEP_LO];
        end
    end

    // set beats a simultaneous clear
    always_ff @(posedge REF_CLK) begin
        if (!blk_rst_n) begin
            expired_reg <= 1'b0;
        end else if (expire_event) begin
            expired_reg <= 1'b1;
        end else if (wr_control && !SFR_WDATA[MST_BIT_EXPIRED]) begin
            expired_reg <= 1'b0;
        end
    end

    // =========================================================
    // interrupt and dma
    always_ff @(posedge REF_CLK) begin
        if (!blk_rst_n) begin
            SLOT_IRQ_PENDING <= 1'b0;
        end else if (expire_event && int_en_reg) begin
            SLOT_IRQ_PENDING <= 1'b1;
        end else if (SLOT_IRQ_PENDING_CLR) begin
            SLOT_IRQ_PENDING <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!blk_rst_n) begin
            SLOT_IRQ           <= 1'b0;
            EXPIRY_DMA_TRIGGER <= 1'b0;
        end else begin
            SLOT_IRQ           <= SLOT_IRQ_PENDING && int_en_reg && SLOT_IRQ_GLOBAL_ENABLE;
            EXPIRY_DMA_TRIGGER <= expire_event;
        end
    end

    // =========================================================
    // read port, one cycle latency
    always_ff @(posedge REF_CLK) begin
        if (!blk_rst_n) begin
            SFR_RDATA <= 8'h00;
        end else if (SFR_RE) begin
            unique case (SFR_ADDR)
                MST_ADDR_COUNT:    SFR_RDATA <= count_reg;
                MST_ADDR_PRESCALE: SFR_RDATA <= prescale_max_reg;
                MST_ADDR_CONTROL:  SFR_RDATA <= {1'b0, expired_reg, 1'b0, int_en_reg,
                                                 1'b0, free_run_reg, step_sel_reg};
                default:           SFR_RDATA <= 8'h00;
            endcase
        end
    end

    // =========================================================
    // checks
    sequence s_expiry;
        expire_event ##1 expired_reg;
    endsequence

    property p_count_dec;
        @(posedge REF_CLK) disable iff (!blk_rst_n)
        edge_pulse && !wr_count && (count_reg != 8'h00)
            |=> count_reg == 8'($past(count_reg) - 8'h01);
    endproperty
    a_count_dec: assert property (p_count_dec)
        else $error("count did not drop by one");

    property p_expired_set;
        @(posedge REF_CLK) disable iff (!blk_rst_n)
        edge_pulse && !wr_count && (count_reg == 8'h01) |-> s_expiry;
    endproperty
    a_expired_set: assert property (p_expired_set)
        else $error("expired flag not set at zero");

    property p_hold_zero;
        @(posedge REF_CLK) disable iff (!blk_rst_n)
        !free_run_reg && (count_reg == 8'h00) && !wr_count |=> count_reg == 8'h00;
    endproperty
    a_hold_zero: assert property (p_hold_zero)
        else $error("count left zero without free run");

    property p_wrap;
        @(posedge REF_CLK) disable iff (!blk_rst_n)
        edge_pulse && free_run_reg && (count_reg == 8'h00) && !wr_count
            |=> count_reg == 8'hFF;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("count did not wrap to all ones");

    property p_pending;
        @(posedge REF_CLK) disable iff (!blk_rst_n)
        expire_event && int_en_reg |=> SLOT_IRQ_PENDING && expired_reg;
    endproperty
    a_pending: assert property (p_pending)
        else $error("pending flag missing with expiry");

    property p_irq_gate;
        @(posedge REF_CLK) disable iff (!blk_rst_n)
        SLOT_IRQ |-> $past(SLOT_IRQ_PENDING && int_en_reg && SLOT_IRQ_GLOBAL_ENABLE);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("irq without both enables");

    property p_write_load;
        @(posedge REF_CLK) disable iff (!blk_rst_n)
        wr_count && !edge_pulse |=> count_reg == $past(SFR_WDATA);
    endproperty
    a_write_load: assert property (p_write_load)
        else $error("written count not loaded");

    property p_write_edge;
        @(posedge REF_CLK) disable iff (!blk_rst_n)
        wr_count && edge_pulse && (SFR_WDATA != 8'h00)
            |=> count_reg == 8'($past(SFR_WDATA) - 8'h01);
    endproperty
    a_write_edge: assert property (p_write_edge)
        else $error("write on edge not decremented");

    property p_dma;
        @(posedge REF_CLK) disable iff (!blk_rst_n)
        expire_event |=> EXPIRY_DMA_TRIGGER ##1 !EXPIRY_DMA_TRIGGER;
    endproperty
    a_dma: assert property (p_dma)
        else $error("dma trigger not a single pulse");

    property p_sticky;
        @(posedge REF_CLK) disable iff (!blk_rst_n)
        wr_control && SFR_WDATA[MST_BIT_EXPIRED] && expired_reg |=> expired_reg;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("writing one changed expired flag");

    property p_wake;
        @(posedge REF_CLK) disable iff (!RSTN)
        SLEEP_WAKE_RESET |=> (count_reg == 8'h00) && !expired_reg && !free_run_reg
                             && (prescale_max_reg == 8'h00) && !SLOT_IRQ_PENDING;
    endproperty
    a_wake: assert property (p_wake)
        else $error("registers not reset after wake");

    property p_no_stray_pending;
        @(posedge REF_CLK) disable iff (!blk_rst_n)
        !SLOT_IRQ_PENDING && !(expire_event && int_en_reg) |=> !SLOT_IRQ_PENDING;
    endproperty
    a_no_stray_pending: assert property (p_no_stray_pending)
        else $error("pending flag set without an enabled expiry");

    // a plain load must never look like an expiry to software
    property p_load_no_expiry;
        @(posedge REF_CLK) disable iff (!blk_rst_n)
        wr_count && !edge_pulse && !expired_reg |=> !expired_reg;
    endproperty
    a_load_no_expiry: assert property (p_load_no_expiry)
        else $error("count write set the expired flag");

endmodule // mst_slot_timer

// ### bench/mac_slot_down_timer_tb.sv
// self-checking bench for the slot down timer, driven through its sfr port.
// assumes the mst_pkg constants and the registered read data of the top module.
`timescale 1ns/1ns
module mac_slot_down_timer_tb;
    import mst_pkg::*;

    // =========================================================
    // signals and instance
    localparam int DLY = 10;
    logic       ref_clk;
    logic       rstn;
    logic [7:0] sfr_addr;
    logic       sfr_we;
    logic       sfr_re;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic [2:0] tick_rate;
    logic       glb_en;
    logic       pend_clr;
    logic       wake_rst;
    logic       pend;
    logic       irq;
    logic       dma;
    int         n_mismatch;
    int         total_checks;
    int         n;

    mst_slot_timer u_mst_slot_timer (
        .REF_CLK               (ref_clk),
        .RSTN                  (rstn),
        .SFR_ADDR              (sfr_addr),
        .SFR_WE                (sfr_we),
        .SFR_RE                (sfr_re),
        .SFR_WDATA             (sfr_wdata),
        .SFR_RDATA             (sfr_rdata),
        .TICK_RATE_SELECT      (tick_rate),
        .SLOT_IRQ_GLOBAL_ENABLE(glb_en),
        .SLOT_IRQ_PENDING_CLR  (pend_clr),
        .SLEEP_WAKE_RESET      (wake_rst),
        .SLOT_IRQ_PENDING      (pend),
        .SLOT_IRQ              (irq),
        .EXPIRY_DMA_TRIGGER    (dma)
    );

    always #50 ref_clk = ~ref_clk;

    // =========================================================
    // tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
        #DLY;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_we    = 1'b1;
        cyc(1);
        sfr_we    = 1'b0;
        // idle edge, so back-to-back calls never retoggle the strobe in one step
        cyc(1);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
        sfr_addr = a;
        sfr_re   = 1'b1;
        cyc(1);
        sfr_re   = 1'b0;
        check(sfr_rdata, exp, what);
        cyc(1);
    endtask

    // bounded wait; a missing pulse ends the run
    task automatic wait_dma(input int lim, output int cnt);
        cnt = 0;
        while (dma !== 1'b1 && cnt < lim) begin
            cyc(1);
            cnt++;
        end
        if (dma !== 1'b1) begin
            check(8'h00, 8'h01, "dma trigger never came");
            tally_and_finish();
        end
    endtask

    // one slot from count 1, measured from the count write to the dma pulse
    task automatic interval(input logic [2:0] rate, input logic [1:0] prescale_step_select,
                            input logic [7:0] pr, input int exp);
        int k;
        tick_rate = rate;
        wr(MST_ADDR_PRESCALE, pr);
        wr(MST_ADDR_CONTROL, {6'h00, prescale_step_select});
        wr(MST_ADDR_COUNT, 8'h01);
        wait_dma(exp + 20, k);
        // the wait opens one idle edge after the count write
        check({7'h00, k >= exp - 1 && k <= exp + 7}, 8'h01, "slot interval length");
        cyc(1);
        check({7'h00, dma}, 8'h00, "dma pulse longer than one cycle");
    endtask

    // =========================================================
    // watchdog: cuts a hang short at 6 ms, about three times the full run length
    initial begin
        #6000000;
        check(8'h00, 8'h01, "watchdog expired");
        tally_and_finish();
    end

    // =========================================================
    // main sequence
    initial begin
        ref_clk = 1'b0;
        rstn = 1'b0;
        sfr_addr = 8'h00;
        sfr_we = 1'b0;
        sfr_re = 1'b0;
        sfr_wdata = 8'h00;
        tick_rate = 3'h0;
        glb_en = 1'b1;
        pend_clr = 1'b0;
        wake_rst = 1'b0;
        n_mismatch = 0;
        total_checks = 0;
        cyc(16);
        rstn = 1'b1;

        rdchk(MST_ADDR_COUNT, MST_COUNT_RST, "count reset");
        rdchk(MST_ADDR_PRESCALE, MST_PRESCALE_RST, "prescale reset");
        rdchk(MST_ADDR_CONTROL, 8'h00, "control reset");
        wr(8'h9F, 8'hAA);
        rdchk(8'h9F, 8'h00, "unmapped read");
        wr(MST_ADDR_PRESCALE, 8'h5A);
        rdchk(MST_ADDR_PRESCALE, 8'h5A, "prescale readback");
        wr(MST_ADDR_CONTROL, 8'hD7);
        rdchk(MST_ADDR_CONTROL, 8'h17, "control masks bit6 and reserved");
        wr(MST_ADDR_CONTROL, 8'h00);
        $display("test registers done");

        // countdown from 3 with interrupt enable
        wr(MST_ADDR_PRESCALE, 8'h01);
        wr(MST_ADDR_CONTROL, 8'h10);
        wr(MST_ADDR_COUNT, 8'h03);
        rdchk(MST_ADDR_COUNT, 8'h03, "count loaded at once");
        wait_dma(400, n);
        // three slots of 64 ticks, less the write and readback edges
        check({7'h00, n >= 189 && n <= 198}, 8'h01, "three slot countdown");
        check({7'h00, pend}, 8'h01, "pending with expiry");
        cyc(1);
        check({7'h00, irq}, 8'h01, "irq with both enables");
        rdchk(MST_ADDR_COUNT, 8'h00, "count at zero");
        rdchk(MST_ADDR_CONTROL, 8'h50, "expired flag set");
        cyc(200);
        rdchk(MST_ADDR_COUNT, 8'h00, "count holds at zero");
        wr(MST_ADDR_CONTROL, 8'h10);
        rdchk(MST_ADDR_CONTROL, 8'h10, "expired flag cleared by zero");
        glb_en = 1'b0;
        cyc(2);
        check({7'h00, irq}, 8'h00, "irq masked by global enable");
        check({7'h00, pend}, 8'h01, "pending sticky");
        glb_en = 1'b1;
        pend_clr = 1'b1;
        cyc(1);
        pend_clr = 1'b0;
        cyc(1);
        check({7'h00, pend}, 8'h00, "pending cleared");
        check({7'h00, irq}, 8'h00, "irq gone with pending");
        $display("test countdown done");

        // free run wraps from zero to all ones
        wr(MST_ADDR_CONTROL, 8'h04);
        wr(MST_ADDR_COUNT, 8'h01);
        wait_dma(100, n);
        check({7'h00, pend}, 8'h00, "no pending without interrupt enable");
        cyc(40);
        rdchk(MST_ADDR_COUNT, 8'h00, "free run reaches zero");
        cyc(30);
        rdchk(MST_ADDR_COUNT, MST_WRAP_VALUE, "free run wraps");
        wr(MST_ADDR_CONTROL, 8'h00);
        // zero count stops the prescaler, so the next slot starts from null
        wr(MST_ADDR_COUNT, 8'h00);
        $display("test free run done");

        // intervals for each step code, tick rate 1, prescale max 2 and prescale zero
        interval(3'h0, 2'h0, 8'h01, 64);
        interval(3'h0, 2'h1, 8'h01, 128);
        interval(3'h0, 2'h2, 8'h01, 256);
        interval(3'h0, 2'h3, 8'h01, 1024);
        interval(3'h1, 2'h0, 8'h01, 128);
        interval(3'h0, 2'h0, 8'h02, 128);
        interval(3'h0, 2'h0, 8'h00, 16384);
        $display("test intervals done");

        // count write landing on the timer edge stores value minus one
        wr(MST_ADDR_PRESCALE, 8'h01);
        wr(MST_ADDR_CONTROL, 8'h00);
        wr(MST_ADDR_COUNT, 8'h02);
        // first edge pulse stands 64 ticks after the write edge
        cyc(63);
        wr(MST_ADDR_COUNT, 8'h20);
        rdchk(MST_ADDR_COUNT, 8'h1F, "write on edge stored minus one");
        wr(MST_ADDR_COUNT, 8'h00);
        $display("test write on edge done");

        // wake from deepest sleep restores reset values
        wr(MST_ADDR_PRESCALE, 8'h33);
        wr(MST_ADDR_CONTROL, 8'h12);
        wr(MST_ADDR_COUNT, 8'h44);
        wake_rst = 1'b1;
        cyc(1);
        wake_rst = 1'b0;
        check({5'h00, pend, irq, dma}, 8'h00, "outputs after wake");
        rdchk(MST_ADDR_COUNT, MST_COUNT_RST, "count after wake");
        rdchk(MST_ADDR_PRESCALE, MST_PRESCALE_RST, "prescale after wake");
        rdchk(MST_ADDR_CONTROL, 8'h00, "control after wake");
        $display("test wake done");
        tally_and_finish();
    end
endmodule // mac_slot_down_timer_tb
